//--- shared/pps_pkg.sv
// Constants for the two-section synthesizer power-save control block.
// Assumes one reference-oscillator clock at 100 MHz and a synchronous reset.
package pps_pkg;
	// Serial word layout, shifted in first bit first, last bit at position 0
	localparam int SER_W = 24;
	localparam int CN_LSB = 0;
	localparam int CN_W = 2;
	localparam int FC_BIT = 2;
	localparam int DIV_LSB = 3;
	localparam int R_W = 14;
	localparam int N_W = 11;

	// Control codes that steer a latched word to its destination
	localparam logic [1:0] CN_IF_REF = 2'h0;
	localparam logic [1:0] CN_RF_REF = 2'h1;
	localparam logic [1:0] CN_IF_N = 2'h2;
	localparam logic [1:0] CN_RF_N = 2'h3;

	// Reset values of the divide latches (smallest legal ratio)
	localparam logic [R_W-1:0] R_RST = 14'h0005;
	localparam logic [N_W-1:0] N_RST = 11'h005;
	localparam logic FC_RST = 1'b1;

	// Pin synchroniser width and pin positions in the synchronised vector
	localparam int SYNC_W = 7;
	localparam int PIN_IF_RUN = 0;
	localparam int PIN_RF_RUN = 1;
	localparam int PIN_SCK = 2;
	localparam int PIN_SDI = 3;
	localparam int PIN_LE = 4;
	localparam int PIN_IF_FP = 5;
	localparam int PIN_RF_FP = 6;

	// Timing, in reference clock cycles; the clock period in ns
	localparam int CLK_PERIOD_NS = 10;
	localparam int LOCK_ERR_CYC = 8;
	localparam int LOCK_CYCLES = 3;
	localparam int WAKE_CMP = 2;
	localparam int PD_LIMIT_CYC = 4;
	localparam int WCNT_W = 5;
endpackage : pps_pkg

//--- verilog/pps_section.sv
// One synthesizer section: counters, phase detector, lock detector.
// Assumes run_in and fp_in are already synchronous to clk_in.
`timescale 1ns/100ps
`default_nettype none
module pps_section #(
	parameter int R_W = pps_pkg::R_W,
	parameter int N_W = pps_pkg::N_W
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic run_in,
	input wire logic fp_in,
	input wire logic fc_in,
	input wire logic [R_W-1:0] r_div_in,
	input wire logic [N_W-1:0] n_div_in,
	output logic pd_val_out,
	output logic pd_oe_out,
	output logic lock_out
);
	logic [R_W-1:0] r_cnt_q;
	logic [N_W-1:0] n_cnt_q;
	logic run_q, up_q, dn_q, bad_q;
	logic [pps_pkg::WCNT_W-1:0] w_cnt_q;
	logic [1:0] limit_q, good_q;
	logic fr_tick, fp_tick, wake, limiting;

	assign fr_tick = run_in && (r_cnt_q == r_div_in - R_W'(1));
	assign fp_tick = run_in && fp_in && (n_cnt_q == n_div_in - N_W'(1));
	assign wake = run_in && !run_q;
	assign limiting = (limit_q != 2'h0);

	// Counters held at zero while asleep, so both restart in step on wake
	always_ff @(posedge clk_in) begin
		if (!rst_n_in || !run_in) begin
			r_cnt_q <= '0;
			n_cnt_q <= '0;
		end else begin
			r_cnt_q <= fr_tick ? '0 : r_cnt_q + R_W'(1);
			if (fp_in)
				n_cnt_q <= fp_tick ? '0 : n_cnt_q + N_W'(1);
		end
	end

	// Phase-frequency detector with error-width measurement
	always_ff @(posedge clk_in) begin
		if (!rst_n_in || !run_in) begin
			up_q <= 1'b0;
			dn_q <= 1'b0;
			w_cnt_q <= '0;
		end else begin
			if ((up_q || fr_tick) && (dn_q || fp_tick)) begin
				up_q <= 1'b0;
				dn_q <= 1'b0;
			end else begin
				up_q <= up_q || fr_tick;
				dn_q <= dn_q || fp_tick;
			end
			if (up_q || dn_q)
				w_cnt_q <= (&w_cnt_q) ? w_cnt_q : w_cnt_q + pps_pkg::WCNT_W'(1);
			else
				w_cnt_q <= '0;
		end
	end

	// Wake window: a few comparisons with the error pulse clipped
	always_ff @(posedge clk_in) begin
		run_q <= rst_n_in && run_in;
		if (!rst_n_in || !run_in)
			limit_q <= 2'h0;
		else if (wake)
			limit_q <= 2'(pps_pkg::WAKE_CMP);
		else if (fr_tick && limiting)
			limit_q <= limit_q - 2'h1;
	end

	// Output drive; floats while asleep and is clipped during wake
	always_ff @(posedge clk_in) begin
		if (!rst_n_in || !run_in) begin
			pd_oe_out <= 1'b0;
			pd_val_out <= 1'b0;
		end else begin
			pd_oe_out <= (up_q || dn_q) &&
				!(limiting && w_cnt_q >= pps_pkg::WCNT_W'(pps_pkg::PD_LIMIT_CYC));
			pd_val_out <= fc_in ? up_q : dn_q;
		end
	end

	// Lock detect; asleep it shows the locked level
	always_ff @(posedge clk_in) begin
		if (!rst_n_in || !run_in) begin
			lock_out <= 1'b1;
			good_q <= 2'h0;
			bad_q <= 1'b0;
		end else if (w_cnt_q >= pps_pkg::WCNT_W'(pps_pkg::LOCK_ERR_CYC)) begin
			lock_out <= 1'b0;
			good_q <= 2'h0;
			bad_q <= 1'b1;
		end else if (fr_tick) begin
			bad_q <= 1'b0;
			if (bad_q)
				good_q <= 2'h0;
			else if (good_q != 2'h3)
				good_q <= good_q + 2'h1;
			if (!bad_q && good_q >= 2'(pps_pkg::LOCK_CYCLES - 1))
				lock_out <= 1'b1;
		end
	end

	AST_SLEEP_STOPS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!run_in |=> (r_cnt_q == '0) && (n_cnt_q == '0))
		else $error("counters ran while asleep");
	AST_SLEEP_OUTPUTS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!run_in |=> !pd_oe_out && lock_out)
		else $error("detector not floated or lock not shown while asleep");
	AST_WAKE_RESUME: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(run_in) |=> (r_cnt_q == R_W'(1)) ##1 (r_cnt_q == R_W'(2)))
		else $error("reference counter did not resume on wake");
	AST_WAKE_LIMIT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(limiting && pd_oe_out) [*6] |-> 1'b0)
		else $error("error pulse not clipped during wake");
	AST_UNLOCK: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		run_in && (w_cnt_q >= pps_pkg::WCNT_W'(pps_pkg::LOCK_ERR_CYC)) |=> !lock_out)
		else $error("lock held on large phase error");
endmodule : pps_section
`default_nettype wire

//--- verilog/pps_top.sv
// Power-save control for a two-section synthesizer, with serial port.
// Assumes all pins but RESETN_IN are asynchronous to MCLK_IN, the reference oscillator.
// The host keeps both run pins low through power-up and reset.
`timescale 1ns/100ps
`default_nettype none
module pps_top (
	input wire logic MCLK_IN,
	input wire logic RESETN_IN,
	input wire logic IF_SECTION_RUN_N_IN,
	input wire logic RF_SECTION_RUN_N_IN,
	input wire logic SER_CLK_IN,
	input wire logic SER_DATA_IN,
	input wire logic SER_LOAD_IN,
	input wire logic IF_DIVIDED_VCO_RATE_IN,
	input wire logic RF_DIVIDED_VCO_RATE_IN,
	output logic IF_PD_OUT,
	output logic IF_PD_OE_OUT,
	output logic RF_PD_OUT,
	output logic RF_PD_OE_OUT,
	output logic LOCK_DETECT_OUT,
	output logic REF_INPUT_BUFFER_EN_OUT
);
	logic [pps_pkg::SYNC_W-1:0] pin_s1_q;
	logic [pps_pkg::SYNC_W-1:0] pin_s2_q;
	logic [pps_pkg::SYNC_W-1:0] pin_s3_q;
	logic [pps_pkg::SER_W-1:0] shift_q;
	logic [pps_pkg::R_W-1:0] if_r_q, rf_r_q;
	logic [pps_pkg::N_W-1:0] if_n_q, rf_n_q;
	logic if_fc_q, rf_fc_q;
	logic if_run_s, rf_run_s;
	logic sck_rise, le_rise, if_fp_pulse, rf_fp_pulse;
	logic if_lock, rf_lock;
	logic [pps_pkg::CN_W-1:0] word_cn;
	logic [pps_pkg::R_W-1:0] word_r;
	logic [pps_pkg::N_W-1:0] word_n;

	// Two-stage synchronisers; the third stage only feeds edge detection
	always_ff @(posedge MCLK_IN) begin
		if (!RESETN_IN) begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
			pin_s3_q <= '0;
		end else begin
			pin_s1_q <= {RF_DIVIDED_VCO_RATE_IN, IF_DIVIDED_VCO_RATE_IN, SER_LOAD_IN,
				SER_DATA_IN, SER_CLK_IN, RF_SECTION_RUN_N_IN, IF_SECTION_RUN_N_IN};
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end

	// Run levels; a high pin means the section runs
	assign if_run_s = pin_s2_q[pps_pkg::PIN_IF_RUN];
	assign rf_run_s = pin_s2_q[pps_pkg::PIN_RF_RUN];

	// Edges taken between the second and third stages
	assign sck_rise = pin_s2_q[pps_pkg::PIN_SCK] && !pin_s3_q[pps_pkg::PIN_SCK];
	assign le_rise = pin_s2_q[pps_pkg::PIN_LE] && !pin_s3_q[pps_pkg::PIN_LE];
	assign if_fp_pulse = pin_s2_q[pps_pkg::PIN_IF_FP] && !pin_s3_q[pps_pkg::PIN_IF_FP];
	assign rf_fp_pulse = pin_s2_q[pps_pkg::PIN_RF_FP] && !pin_s3_q[pps_pkg::PIN_RF_FP];

	// Serial shift register; data and clock share the same sync delay,
	// so the data bit is the one present at the clock's rising edge
	always_ff @(posedge MCLK_IN) begin
		if (!RESETN_IN)
			shift_q <= '0;
		else if (sck_rise)
			shift_q <= {shift_q[pps_pkg::SER_W-2:0], pin_s2_q[pps_pkg::PIN_SDI]};
	end

	// Fields of the word waiting in the shift register
	assign word_cn = shift_q[pps_pkg::CN_LSB +: pps_pkg::CN_W];
	assign word_r = shift_q[pps_pkg::DIV_LSB +: pps_pkg::R_W];
	assign word_n = shift_q[pps_pkg::DIV_LSB +: pps_pkg::N_W];

	// Latch update on a load edge; deliberately not gated by the run
	// pins, so ratios can be loaded while a section sleeps
	always_ff @(posedge MCLK_IN) begin
		if (!RESETN_IN) begin
			if_r_q <= pps_pkg::R_RST;
			rf_r_q <= pps_pkg::R_RST;
		end else if (le_rise) begin
			if (word_cn == pps_pkg::CN_IF_REF)
				if_r_q <= word_r;
			if (word_cn == pps_pkg::CN_RF_REF)
				rf_r_q <= word_r;
		end
	end

	// Comparison divider latches with the detector polarity bit
	always_ff @(posedge MCLK_IN) begin
		if (!RESETN_IN) begin
			if_n_q <= pps_pkg::N_RST;
			rf_n_q <= pps_pkg::N_RST;
			if_fc_q <= pps_pkg::FC_RST;
			rf_fc_q <= pps_pkg::FC_RST;
		end else if (le_rise) begin
			if (word_cn == pps_pkg::CN_IF_N) begin
				if_n_q <= word_n;
				if_fc_q <= shift_q[pps_pkg::FC_BIT];
			end
			if (word_cn == pps_pkg::CN_RF_N) begin
				rf_n_q <= word_n;
				rf_fc_q <= shift_q[pps_pkg::FC_BIT];
			end
		end
	end

	// Lower section
	pps_section #(
		.R_W(pps_pkg::R_W),
		.N_W(pps_pkg::N_W)
	) u_if_section (
		.clk_in(MCLK_IN),
		.rst_n_in(RESETN_IN),
		.run_in(if_run_s),
		.fp_in(if_fp_pulse),
		.fc_in(if_fc_q),
		.r_div_in(if_r_q),
		.n_div_in(if_n_q),
		.pd_val_out(IF_PD_OUT),
		.pd_oe_out(IF_PD_OE_OUT),
		.lock_out(if_lock)
	);

	// Upper section, independent of the lower one
	pps_section #(
		.R_W(pps_pkg::R_W),
		.N_W(pps_pkg::N_W)
	) u_rf_section (
		.clk_in(MCLK_IN),
		.rst_n_in(RESETN_IN),
		.run_in(rf_run_s),
		.fp_in(rf_fp_pulse),
		.fc_in(rf_fc_q),
		.r_div_in(rf_r_q),
		.n_div_in(rf_n_q),
		.pd_val_out(RF_PD_OUT),
		.pd_oe_out(RF_PD_OE_OUT),
		.lock_out(rf_lock)
	);

	// Combined lock; a sleeping section reads as locked so it never
	// pulls the shared indicator low
	always_ff @(posedge MCLK_IN) begin
		if (!RESETN_IN)
			LOCK_DETECT_OUT <= 1'b1;
		else
			LOCK_DETECT_OUT <= if_lock && rf_lock;
	end

	// Shared oscillator buffer runs while either section runs
	always_ff @(posedge MCLK_IN) begin
		if (!RESETN_IN)
			REF_INPUT_BUFFER_EN_OUT <= 1'b0;
		else
			REF_INPUT_BUFFER_EN_OUT <= if_run_s || rf_run_s;
	end

	AST_IF_SLEEP_ALONE: assert property (@(posedge MCLK_IN) disable iff (!RESETN_IN)
		(!if_run_s && rf_run_s) |=> !IF_PD_OE_OUT && REF_INPUT_BUFFER_EN_OUT)
		else $error("lower section sleep not independent");
	AST_RF_SLEEP_ALONE: assert property (@(posedge MCLK_IN) disable iff (!RESETN_IN)
		(!rf_run_s && if_run_s) |=> !RF_PD_OE_OUT && REF_INPUT_BUFFER_EN_OUT)
		else $error("upper section sleep not independent");
	AST_PIN_TO_BUFFER: assert property (@(posedge MCLK_IN) disable iff (!RESETN_IN)
		##4 REF_INPUT_BUFFER_EN_OUT ==
		($past(IF_SECTION_RUN_N_IN, 3) || $past(RF_SECTION_RUN_N_IN, 3)))
		else $error("oscillator buffer enable wrong");
	AST_BUFFER_OFF: assert property (@(posedge MCLK_IN) disable iff (!RESETN_IN)
		(!if_run_s && !rf_run_s) [*2] |-> !REF_INPUT_BUFFER_EN_OUT)
		else $error("oscillator buffer on with both asleep");
	AST_SHIFT_BIT: assert property (@(posedge MCLK_IN) disable iff (!RESETN_IN)
		sck_rise |=> shift_q[0] == $past(pin_s2_q[pps_pkg::PIN_SDI])
		&& shift_q[pps_pkg::SER_W-1:1] == $past(shift_q[pps_pkg::SER_W-2:0]))
		else $error("serial bit not shifted on clock rise");
	AST_LATCH_ASLEEP: assert property (@(posedge MCLK_IN) disable iff (!RESETN_IN)
		le_rise && !if_run_s && (word_cn == pps_pkg::CN_IF_REF) |=> if_r_q == $past(word_r))
		else $error("reference ratio not latched while asleep");
	AST_LOCK_COMBINE: assert property (@(posedge MCLK_IN) disable iff (!RESETN_IN)
		(!if_lock || !rf_lock) |=> !LOCK_DETECT_OUT)
		else $error("combined lock high with a section unlocked");
endmodule : pps_top
`default_nettype wire

//--- sim/pps_host.sv
// Host model: run pins, serial programming port and divided VCO lines.
// Assumes one reference clock; every pin change follows its rising edge.
`timescale 1ns/100ps
`default_nettype none
module pps_host (
	input wire logic clk_in,
	input wire logic rst_n_in,
	output logic if_run_n_out,
	output logic rf_run_n_out,
	output logic sck_out,
	output logic sdi_out,
	output logic load_out,
	output logic if_fp_out,
	output logic rf_fp_out
);
	// Clock-stable wait before any wake, 1 us at 100 MHz
	localparam int WAKE_WAIT = 100;
	int settle_q;

	// Both sections asleep from power-on; VCO lines idle so no loop closes
	initial begin
		if_run_n_out = 1'b0;
		rf_run_n_out = 1'b0;
		sck_out = 1'b0;
		sdi_out = 1'b0;
		load_out = 1'b0;
		if_fp_out = 1'b0;
		rf_fp_out = 1'b0;
	end

	// Counts stable-clock cycles since reset release
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			settle_q <= 0;
		end else if (settle_q < WAKE_WAIT) begin
			settle_q <= settle_q + 1;
		end
	end

	// A rise is held back until the clock has been stable long enough
	task automatic set_run(input int sec, input logic lvl);
		while (lvl && settle_q < WAKE_WAIT) @(posedge clk_in);
		@(posedge clk_in);
		if (sec == 0) begin
			if_run_n_out <= lvl;
		end else begin
			rf_run_n_out <= lvl;
		end
	endtask : set_run

	// First bit first; low halves of 4 cycles and high halves of 5 beat the 3-cycle minimum
	task automatic send_word(input logic [pps_pkg::SER_W-1:0] w);
		for (int i = pps_pkg::SER_W - 1; i >= 0; i--) begin
			@(posedge clk_in);
			sdi_out <= w[i];
			sck_out <= 1'b0;
			repeat (4) @(posedge clk_in);
			sck_out <= 1'b1;
			repeat (4) @(posedge clk_in);
		end
		sdi_out <= ~w[0]; // Data line flipped from the last bit so it shows no stale bit
		load_out <= 1'b1;
		repeat (8) @(posedge clk_in);
		load_out <= 1'b0;
		sck_out <= 1'b0;
	endtask : send_word
endmodule : pps_host
`default_nettype wire

//--- sim/tb.sv
// Self-checking bench for the power-save control block.
// Assumes the host model in pps_host.sv; both VCO lines stay idle.
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic mclk, resetn, sck, sdi, load, if_run_n, rf_run_n, if_fp, rf_fp;
	logic if_pd, if_oe, rf_pd, rf_oe, lock, buf_en;
	logic [1:0] oe, pd;
	int errors = 0;
	int compares = 0;

	// Per-section views, indexed 0 = lower, 1 = upper
	assign oe = {rf_oe, if_oe};
	assign pd = {rf_pd, if_pd};

	// 100 MHz reference clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	pps_top dut (.MCLK_IN(mclk), .RESETN_IN(resetn), .IF_SECTION_RUN_N_IN(if_run_n),
		.RF_SECTION_RUN_N_IN(rf_run_n), .SER_CLK_IN(sck), .SER_DATA_IN(sdi),
		.SER_LOAD_IN(load), .IF_DIVIDED_VCO_RATE_IN(if_fp), .RF_DIVIDED_VCO_RATE_IN(rf_fp),
		.IF_PD_OUT(if_pd), .IF_PD_OE_OUT(if_oe), .RF_PD_OUT(rf_pd), .RF_PD_OE_OUT(rf_oe),
		.LOCK_DETECT_OUT(lock), .REF_INPUT_BUFFER_EN_OUT(buf_en));

	pps_host u_host (.clk_in(mclk), .rst_n_in(resetn), .if_run_n_out(if_run_n),
		.rf_run_n_out(rf_run_n), .sck_out(sck), .sdi_out(sdi), .load_out(load),
		.if_fp_out(if_fp), .rf_fp_out(rf_fp));

	task automatic results();
		$display("Checks %0d, mismatches %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : results

	task automatic check(input string name, input logic seen, input logic exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %b seen %b", name, exp, seen);
		end
	endtask : check

	// Samples 1 ns after the edge so that its updates have landed
	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : step

	// Wake one section; with no divided VCO the reference always leads
	task automatic t_wake(input int sec, input logic pol, input logic alone);
		int run, most, n;
		run = 0;
		most = 0;
		u_host.set_run(sec, 1'b1);
		step(4);
		check("buffer enable on wake", buf_en, 1'b1);
		if (alone) check("other section floats", oe[1-sec], 1'b0);
		for (n = 0; n < 10; n++) begin
			run = (oe[sec] === 1'b1) ? run + 1 : 0;
			if (run > most) most = run;
			step(1);
		end
		check("wake drive clipped", most <= pps_pkg::PD_LIMIT_CYC, 1'b1);
		n = 0;
		while (oe[sec] !== 1'b1 && n < 200) begin
			step(1);
			n++;
		end
		if (n == 200) begin
			errors++;
			results();
		end
		check("detector sign", pd[sec], pol);
		step(100);
		check("lock lost on large error", lock, 1'b0);
	endtask : t_wake

	// Sleep one section and watch its detector stay released
	task automatic t_sleep(input int sec, input logic exp_buf);
		u_host.set_run(sec, 1'b0);
		step(4);
		check("buffer enable on sleep", buf_en, exp_buf);
		for (int n = 0; n < 40; n++) begin
			check("asleep detector floats", oe[sec], 1'b0);
			step(1);
		end
		if (!exp_buf) check("asleep lock shown", lock, 1'b1);
	endtask : t_sleep

	// Main sequence: reset, wake and sleep each section, reprogram asleep
	initial begin
		resetn = 1'b0;
		repeat (8) @(posedge mclk);
		resetn <= 1'b1;
		step(1);
		check("reset lower drive", if_oe, 1'b0);
		check("reset upper drive", rf_oe, 1'b0);
		check("reset lock", lock, 1'b1);
		check("reset buffer", buf_en, 1'b0);
		t_wake(0, 1'b1, 1'b1);
		t_sleep(0, 1'b0);
		// Lower N word, N = 5, polarity 0, loaded while both sleep
		u_host.send_word(24'h00_002A);
		step(8);
		t_wake(0, 1'b0, 1'b1);
		t_wake(1, 1'b1, 1'b0);
		t_sleep(0, 1'b1);
		t_sleep(1, 1'b0);
		results();
	end
endmodule : tb
`default_nettype wire
